// ==== src/sram_burst_ctrl.sv ====
// memory controller end of the burst-of-four sram link
`timescale 1ns/100ps
`default_nettype none
module sram_burst_ctrl (
    input wire logic i_clk, // system clock
    input wire logic i_nrst, // async reset, active low
    input wire logic i_rd_req, // read burst request
    input wire logic i_wr_req, // write burst request
    input wire sram_link_pkg::addr_t i_addr, // burst address
    input wire sram_link_pkg::burst_t i_wr_data, // four write words
    input wire sram_link_pkg::burst_mask_t i_wr_mask_n, // lanes, low
    input wire logic i_relock, // clock changed, redo dll lock
    input wire logic i_pause, // stop the link clock when idle
    output logic o_ready, // request taken this cycle if raised
    output logic o_locked, // dll lock wait done
    output sram_link_pkg::burst_t o_rd_data, // four read words
    output logic o_rd_valid, // read burst complete pulse
    sram_link.ctrl link // sram-facing pins
);
    typedef enum logic [2:0] {
        ST_STOP = 3'h0,
        ST_LOCK = 3'h1,
        ST_IDLE = 3'h2,
        ST_RUN = 3'h3,
        ST_PAUSE = 3'h4
    } ctl_state_t;

    // whole state of the controller
    typedef struct packed {
        ctl_state_t st;
        logic [1:0] ph; // position inside one beat
        logic lk;
        logic kpos;
        logic rd_n;
        logic wr_n;
        sram_link_pkg::addr_t addr;
        sram_link_pkg::word_t d;
        sram_link_pkg::lanes_t en_n;
        logic [11:0] cnt;
        logic [2:0] bc; // beat of current burst
        logic op_wr;
        sram_link_pkg::burst_t wbuf;
        sram_link_pkg::burst_mask_t mbuf;
        sram_link_pkg::burst_t rbuf;
        logic [1:0] widx;
        logic rd_pulse;
        sram_link_pkg::word_t q_s1;
        sram_link_pkg::word_t q_s2;
        logic qv_s1;
        logic qv_s2;
        logic ec_s1;
        logic ec_s2;
        logic ec_s3;
    } ctl_reg_t;

    ctl_reg_t s;
    ctl_reg_t n;
    logic run;
    logic fall;
    logic [2:0] nb;

    // beat timing and request acceptance
    always_comb begin
        run = (s.st == ST_LOCK) | (s.st == ST_IDLE) | (s.st == ST_RUN);
        fall = run & (s.ph == 2'h3);
        nb = s.bc + 3'h1;
        // commands only go out ahead of a k edge
        o_ready = (s.st == ST_IDLE) & fall & ~s.kpos & ~i_relock;
    end

    // next state
    always_comb begin
        n = s;
        n.rd_pulse = 1'b0;
        // sram outputs pass two flops before use
        n.q_s1 = link.q;
        n.q_s2 = s.q_s1;
        n.qv_s1 = link.q_valid;
        n.qv_s2 = s.qv_s1;
        n.ec_s1 = link.echo_clock;
        n.ec_s2 = s.ec_s1;
        n.ec_s3 = s.ec_s2;
        // divider makes the link clock; pins change as it falls
        if (run) begin
            n.ph = s.ph + 2'h1;
            n.lk = n.ph[1];
        end else begin
            n.ph = 2'h0;
            n.lk = 1'b0;
        end
        if (fall) begin
            n.kpos = ~s.kpos;
            n.rd_n = 1'b1;
            n.wr_n = 1'b1;
            n.en_n = sram_link_pkg::LANES_OFF_N;
        end
        case (s.st)
            ST_STOP: begin
                // clock held still to reset the dll
                n.cnt = s.cnt + 12'h1;
                if (s.cnt ==
                    12'(sram_link_pkg::STOP_CYCLES - 1)) begin
                    n.st = ST_LOCK;
                    n.cnt = '0;
                end
            end
            ST_LOCK: begin
                // count stable k cycles before any command
                if (fall && !s.kpos) begin
                    n.cnt = s.cnt + 12'h1;
                    if (s.cnt ==
                        12'(sram_link_pkg::DLL_LOCK_CYCLES - 1)) begin
                        n.st = ST_IDLE;
                    end
                end
            end
            ST_IDLE: begin
                if (fall && i_relock) begin
                    n.st = ST_STOP;
                    n.cnt = '0;
                end else if (o_ready && i_wr_req) begin
                    n.wr_n = 1'b0;
                    n.addr = i_addr;
                    n.op_wr = 1'b1;
                    n.bc = '0;
                    n.wbuf = i_wr_data;
                    n.mbuf = i_wr_mask_n;
                    n.st = ST_RUN;
                end else if (o_ready && i_rd_req) begin
                    n.rd_n = 1'b0;
                    n.addr = i_addr;
                    n.op_wr = 1'b0;
                    n.bc = '0;
                    n.widx = '0;
                    n.st = ST_RUN;
                end else if (fall && i_pause) begin
                    // device is idle here, so stopping is safe
                    n.st = ST_PAUSE;
                end
            end
            ST_RUN: begin
                if (fall) begin
                    n.bc = nb;
                    if (s.op_wr && nb >= 3'(sram_link_pkg::WR_LAT_BEATS) &&
                        nb <= sram_link_pkg::WR_LAST_BEAT) begin
                        // data from the next k edge, four beats
                        // lanes stay off once the last beat is out
                        n.d = s.wbuf[2'(nb - 3'h2)];
                        n.en_n = s.mbuf[2'(nb - 3'h2)];
                    end
                    if (s.op_wr && s.bc == sram_link_pkg::WR_LAST_BEAT) begin
                        n.st = ST_IDLE;
                    end
                end
                // read words arrive one per echo change
                if (!s.op_wr && (s.ec_s2 ^ s.ec_s3) && s.qv_s2) begin
                    n.rbuf[s.widx] = s.q_s2;
                    n.widx = s.widx + 2'h1;
                    if (s.widx == 2'h3) begin
                        n.rd_pulse = 1'b1;
                        n.st = ST_IDLE;
                    end
                end
            end
            ST_PAUSE: begin
                if (!i_pause) begin
                    n.st = ST_IDLE;
                end
            end
            default: begin
                n.st = ST_STOP;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s <= '{st: ST_STOP, rd_n: 1'b1, wr_n: 1'b1,
                en_n: sram_link_pkg::LANES_OFF_N, default: '0};
        end else begin
            s <= n;
        end
    end

    // pins and user outputs from flops
    assign link.k = s.lk;
    assign link.k_pos = s.kpos;
    assign link.rd_sel_n = s.rd_n;
    assign link.wr_sel_n = s.wr_n;
    assign link.addr = s.addr;
    assign link.d = s.d;
    assign link.lane_write_en_n = s.en_n;
    assign o_locked = (s.st == ST_IDLE) | (s.st == ST_RUN) |
        (s.st == ST_PAUSE);
    assign o_rd_data = s.rbuf;
    assign o_rd_valid = s.rd_pulse;

endmodule
`default_nettype wire

// ==== include/sram_link_pkg.sv ====
// shared constants and types for the burst-of-four sram link
package sram_link_pkg;
    // data organisation: four lanes of nine bits
    localparam int DATA_W = 36;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int ADDR_W = 6;
    localparam int BURST = 4;
    localparam int IDX_W = ADDR_W + 2;
    // read data latency of 2.5 k cycles, counted in beats
    localparam int RD_LAT_BEATS = 5;
    // write data starts at the next k edge, two beats later
    localparam int WR_LAT_BEATS = 2;
    // last write data beat, counted from the command beat
    localparam logic [2:0] WR_LAST_BEAT = 3'h5;
    // dll lock needs this many stable k cycles
    localparam int DLL_LOCK_CYCLES = 2048;
    // link clock must stand still this long to reset the dll
    localparam int CLK_PERIOD_NS = 100;
    localparam int STOP_MIN_NS = 30;
    localparam int STOP_CYCLES_RAW =
        (STOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STOP_CYCLES = (STOP_CYCLES_RAW < 1) ? 1 : STOP_CYCLES_RAW;
    // reset and idle values of the pins
    localparam logic [LANES-1:0] LANES_OFF_N = 4'hF;

    typedef logic [DATA_W-1:0] word_t;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [IDX_W-1:0] idx_t;
    typedef logic [LANES-1:0] lanes_t;
    typedef word_t [BURST-1:0] burst_t;
    typedef lanes_t [BURST-1:0] burst_mask_t;
endpackage

// ==== include/sram_link.sv ====
// pin-level link between the memory controller and the sram
`timescale 1ns/100ps
`default_nettype none
interface sram_link;
    logic k; // beat clock, one rising edge per data beat
    logic k_pos; // high when the coming beat edge is a k edge
    logic rd_sel_n; // read select, active low
    logic wr_sel_n; // write select, active low
    sram_link_pkg::addr_t addr; // burst address
    sram_link_pkg::word_t d; // write data
    sram_link_pkg::lanes_t lane_write_en_n; // byte-lane enables, low
    sram_link_pkg::word_t q; // read data driven by the sram
    logic q_oe; // sram drives q
    logic q_valid; // q holds a read word
    logic echo_clock; // toggles once per beat

    modport device (
        input k, k_pos, rd_sel_n, wr_sel_n, addr, d, lane_write_en_n,
        output q, q_oe, q_valid, echo_clock
    );
    modport ctrl (
        output k, k_pos, rd_sel_n, wr_sel_n, addr, d, lane_write_en_n,
        input q, q_oe, q_valid, echo_clock
    );
endinterface
`default_nettype wire

// ==== src/sram_burst_device.sv ====
// burst-of-four double-rate sram end of the link
`timescale 1ns/100ps
`default_nettype none
module sram_burst_device (
    input wire logic i_nrst, // async reset, active low
    sram_link.device link, // controller-facing pins
    output logic o_busy // read or write burst pending
);
    localparam int RL = sram_link_pkg::RD_LAT_BEATS;
    localparam int WL = sram_link_pkg::WR_LAT_BEATS;
    localparam int DEPTH = 2 ** sram_link_pkg::IDX_W;

    // state of the sram end except the storage array, registered on the beat clock
    typedef struct packed {
        logic [RL-1:0] rd_v; // read commands waiting for latency
        sram_link_pkg::addr_t [RL-1:0] rd_a;
        logic [WL-1:0] wr_v; // write commands waiting for data
        sram_link_pkg::addr_t [WL-1:0] wr_a;
        logic rd_prev; // read initiated at previous k edge
        logic wr_prev; // write initiated at previous k edge
        logic [1:0] rd_left; // read words still to send
        logic [1:0] rd_beat;
        sram_link_pkg::addr_t rd_addr;
        logic [1:0] wr_left; // write beats still to take
        logic [1:0] wr_beat;
        sram_link_pkg::addr_t wr_addr;
        sram_link_pkg::word_t q;
        logic q_oe;
        logic q_valid;
        logic echo;
    } dev_state_t;

    dev_state_t st;
    dev_state_t next_st;

    // storage array, four words per burst address
    sram_link_pkg::word_t mem [DEPTH];

    logic rd_start;
    logic wr_start;
    logic mem_we;
    sram_link_pkg::idx_t mem_widx;
    sram_link_pkg::lanes_t mem_lanes;
    sram_link_pkg::idx_t rd_idx;

    // word index of one beat inside a burst
    function automatic sram_link_pkg::idx_t burst_idx(
        input sram_link_pkg::addr_t a,
        input logic [1:0] beat
    );
        burst_idx = {a, beat};
    endfunction

    // command decode at k edges only
    always_comb begin
        // a select that just initiated cannot start again
        rd_start = link.k_pos & ~link.rd_sel_n & ~st.rd_prev;
        wr_start = link.k_pos & ~link.wr_sel_n & ~st.wr_prev;
    end

    // next state: command pipes, read output, write beats
    always_comb begin
        next_st = st;
        mem_we = 1'b0;
        mem_widx = '0;
        mem_lanes = '0;
        rd_idx = '0;

        // echo clock follows every beat while the link clock runs
        next_st.echo = ~st.echo;

        // initiation history is only kept at k edges
        if (link.k_pos) begin
            next_st.rd_prev = rd_start;
            next_st.wr_prev = wr_start;
        end

        // read commands wait out the latency in a beat pipe
        next_st.rd_v = {st.rd_v[RL-2:0], rd_start};
        next_st.rd_a = {st.rd_a[RL-2:0], link.addr};

        // write commands wait for the next k edge
        next_st.wr_v = {st.wr_v[WL-2:0], wr_start};
        next_st.wr_a = {st.wr_a[WL-2:0], link.addr};

        // read output: first word five beats after the command
        if (st.rd_v[RL-1]) begin
            rd_idx = burst_idx(st.rd_a[RL-1], 2'h0);
            next_st.q = mem[rd_idx];
            next_st.q_oe = 1'b1;
            next_st.q_valid = 1'b1;
            next_st.rd_addr = st.rd_a[RL-1];
            next_st.rd_beat = 2'h1;
            next_st.rd_left = 2'h3;
        end else if (st.rd_left != 2'h0) begin
            // remaining words on following k# and k edges
            rd_idx = burst_idx(st.rd_addr, st.rd_beat);
            next_st.q = mem[rd_idx];
            next_st.q_oe = 1'b1;
            next_st.q_valid = 1'b1;
            next_st.rd_beat = st.rd_beat + 2'h1;
            next_st.rd_left = st.rd_left - 2'h1;
        end else begin
            // no burst pending: outputs float, last word kept
            next_st.q_oe = 1'b0;
            next_st.q_valid = 1'b0;
        end

        // write beats: lane enables only count inside a burst
        if (st.wr_v[WL-1]) begin
            mem_we = 1'b1;
            mem_widx = burst_idx(st.wr_a[WL-1], 2'h0);
            mem_lanes = ~link.lane_write_en_n;
            next_st.wr_addr = st.wr_a[WL-1];
            next_st.wr_beat = 2'h1;
            next_st.wr_left = 2'h3;
        end else if (st.wr_left != 2'h0) begin
            mem_we = 1'b1;
            mem_widx = burst_idx(st.wr_addr, st.wr_beat);
            mem_lanes = ~link.lane_write_en_n;
            next_st.wr_beat = st.wr_beat + 2'h1;
            next_st.wr_left = st.wr_left - 2'h1;
        end
    end

    // state register; a stopped link clock freezes every pin
    always_ff @(posedge link.k or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // lane-masked storage write, nine bits per enable
    always_ff @(posedge link.k) begin
        for (int l = 0; l < sram_link_pkg::LANES; l++) begin
            if (mem_we && mem_lanes[l]) begin
                // lane 0 bits 0-8 up to lane 3 bits 27-35
                mem[mem_widx][l*sram_link_pkg::LANE_W +:
                    sram_link_pkg::LANE_W] <=
                    link.d[l*sram_link_pkg::LANE_W +:
                    sram_link_pkg::LANE_W];
            end
        end
    end

    // pins come straight from the state flops
    assign link.q = st.q;
    assign link.q_oe = st.q_oe;
    assign link.q_valid = st.q_valid;
    assign link.echo_clock = st.echo;

    // pending work, so the bench can check that stopping was safe
    assign o_busy = (|st.rd_v) | (|st.wr_v) | (st.rd_left != 2'h0) |
        (st.wr_left != 2'h0) | st.q_valid;

endmodule
`default_nettype wire

// ==== dv/sram_link_sva.sv ====
// concurrent checks on the pins between controller and sram
`timescale 1ns/100ps
`default_nettype none
module sram_link_sva (
    input wire logic i_nrst, // async reset, active low
    input wire logic k, // beat clock
    input wire logic k_pos, // coming edge is a k edge
    input wire logic rd_sel_n, // read select, low
    input wire logic wr_sel_n, // write select, low
    input wire sram_link_pkg::lanes_t lane_write_en_n, // lane enables
    input wire sram_link_pkg::word_t q, // read data
    input wire logic q_oe, // sram drives q
    input wire logic q_valid // q holds a read word
);
    logic rd_hist;
    logic wr_hist;
    logic [11:0] lock_cnt;
    logic rd_take;
    logic wr_take;

    // burst starts, second same select in a row is ignored
    assign rd_take = k_pos && !rd_sel_n && !rd_hist;
    assign wr_take = k_pos && !wr_sel_n && !wr_hist;

    // select history and saturating count of k edges since reset
    always_ff @(posedge k or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_hist <= 1'b0;
            wr_hist <= 1'b0;
            lock_cnt <= 12'h000;
        end else if (k_pos) begin
            rd_hist <= rd_take;
            wr_hist <= wr_take;
            if (!lock_cnt[11]) begin
                lock_cnt <= lock_cnt + 12'h001;
            end
        end
    end

    default clocking cb @(posedge k); endclocking
    default disable iff (!i_nrst);

    sequence s_rd_cmd;
        k_pos && !rd_sel_n && !rd_hist;
    endsequence
    sequence s_rd_burst;
        (q_valid && q_oe) [*4];
    endsequence

    property p_rd_latency;
        s_rd_cmd |=> (!q_valid) [*5] ##1 s_rd_burst;
    endproperty
    a_rd_latency: assert property (p_rd_latency)
        else $error("read words not on the fifth to eighth beat");
    property p_rd_origin;
        $rose(q_valid) |-> $past(rd_take, 6);
    endproperty
    a_rd_origin: assert property (p_rd_origin)
        else $error("read data without a read five beats back");
    property p_oe_valid;
        q_oe == q_valid;
    endproperty
    a_oe_valid: assert property (p_oe_valid)
        else $error("q driven outside a read burst");
    property p_rd_once;
        s_rd_cmd |-> ##2 rd_sel_n;
    endproperty
    a_rd_once: assert property (p_rd_once)
        else $error("read select low on two k edges running");
    property p_wr_once;
        k_pos && !wr_sel_n |-> ##2 wr_sel_n;
    endproperty
    a_wr_once: assert property (p_wr_once)
        else $error("write select low on two k edges running");
    property p_lane_window;
        lane_write_en_n != sram_link_pkg::LANES_OFF_N |->
            $past(wr_take, 2) || $past(wr_take, 3) ||
            $past(wr_take, 4) || $past(wr_take, 5);
    endproperty
    a_lane_window: assert property (p_lane_window)
        else $error("lane enable low outside write beats");
    property p_lock_wait;
        k_pos && !(rd_sel_n && wr_sel_n) |-> lock_cnt[11];
    endproperty
    a_lock_wait: assert property (p_lock_wait)
        else $error("command before the dll lock wait");
    property p_q_hold;
        !q_valid && !$past(q_valid) |-> $stable(q);
    endproperty
    a_q_hold: assert property (p_q_hold)
        else $error("q changed outside a read burst");
endmodule
`default_nettype wire

// ==== dv/test_quad_rate_burst4_sram_port.sv ====
// self-checking bench joining controller and sram ends
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
    failures++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); \
    end end
module test_quad_rate_burst4_sram_port;
    logic i_clk, i_nrst, i_rd_req, i_wr_req, i_relock, i_pause;
    sram_link_pkg::addr_t i_addr;
    sram_link_pkg::burst_t i_wr_data, o_rd_data;
    sram_link_pkg::burst_mask_t i_wr_mask_n;
    logic o_ready, o_locked, o_rd_valid, o_busy;
    int failures, check_count, n;
    logic [31:0] lfsr;
    sram_link_pkg::word_t mem [256];
    logic known [256];
    logic [3:0] mask_tab [8] = '{4'h0, 4'hE, 4'hD, 4'hB, 4'h7, 4'hC,
        4'h3, 4'hF};

    sram_link link_if();
    sram_burst_ctrl sram_burst_ctrl_inst (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_rd_req(i_rd_req), .i_wr_req(i_wr_req), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_mask_n(i_wr_mask_n),
        .i_relock(i_relock), .i_pause(i_pause), .o_ready(o_ready),
        .o_locked(o_locked), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .link(link_if));
    sram_burst_device sram_burst_device_inst (.i_nrst(i_nrst),
        .link(link_if), .o_busy(o_busy));
    sram_link_sva sram_link_sva_inst (.i_nrst(i_nrst), .k(link_if.k),
        .k_pos(link_if.k_pos), .rd_sel_n(link_if.rd_sel_n),
        .wr_sel_n(link_if.wr_sel_n),
        .lane_write_en_n(link_if.lane_write_en_n), .q(link_if.q),
        .q_oe(link_if.q_oe), .q_valid(link_if.q_valid));

    // system clock, 100 ns
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // next value of the stimulus shift register
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    // expected word after a lane-masked write
    function automatic sram_link_pkg::word_t merge(
        input sram_link_pkg::word_t old, input sram_link_pkg::word_t nw,
        input sram_link_pkg::lanes_t m);
        sram_link_pkg::word_t r;
        r = old;
        for (int l = 0; l < 4; l++) begin
            if (!m[l]) r[l*9 +: 9] = nw[l*9 +: 9];
        end
        return r;
    endfunction

    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic give_up(input string what);
        failures++;
        $display("[FAIL] %0t timeout %s", $time, what);
        final_report();
    endtask

    // one burst request; reads are compared against the model
    task automatic issue(input logic wr, input sram_link_pkg::addr_t a,
        input sram_link_pkg::burst_t wd,
        input sram_link_pkg::burst_mask_t m);
        int c;
        sram_link_pkg::idx_t ix;
        @(posedge i_clk);
        i_addr <= a;
        i_wr_data <= wd;
        i_wr_mask_n <= m;
        i_wr_req <= wr;
        i_rd_req <= !wr;
        c = 0;
        do begin @(negedge i_clk); c++; end
        while (o_ready !== 1'b1 && c < 40000);
        if (c >= 40000) give_up("request");
        @(posedge i_clk);
        i_wr_req <= 1'b0;
        i_rd_req <= 1'b0;
        if (wr) begin
            for (int j = 0; j < 4; j++) begin
                ix = {a, j[1:0]};
                if (known[ix]) mem[ix] = merge(mem[ix], wd[j], m[j]);
                else if (m[j] == 4'h0) begin
                    mem[ix] = wd[j];
                    known[ix] = 1'b1;
                end
            end
        end else begin
            c = 0;
            do begin @(negedge i_clk); c++; end
            while (o_rd_valid !== 1'b1 && c < 200);
            if (c >= 200) give_up("read");
            for (int j = 0; j < 4; j++) begin
                ix = {a, j[1:0]};
                if (known[ix]) `CHK(o_rd_data[j], mem[ix])
            end
        end
    endtask

    task automatic wait_lock(output int c);
        c = 0;
        while (o_locked !== 1'b1 && c < 40000) begin
            @(posedge i_clk);
            c++;
        end
        if (c >= 40000) give_up("lock");
    endtask

    // random burst data and masks
    task automatic rand_burst(output sram_link_pkg::burst_t wd,
        output sram_link_pkg::burst_mask_t m);
        logic [31:0] v, w;
        for (int j = 0; j < 4; j++) begin
            v = rnd();
            w = rnd();
            wd[j] = {w[3:0], v};
            m[j] = w[7:4];
        end
    endtask

    // main sequence
    initial begin
        sram_link_pkg::burst_t wd;
        sram_link_pkg::burst_mask_t m;
        logic [31:0] v;
        logic k0, moved;
        i_nrst = 1'b0;
        {i_rd_req, i_wr_req, i_relock, i_pause} = 4'h0;
        i_addr = '0;
        i_wr_data = '0;
        i_wr_mask_n = '1;
        lfsr = 32'h246e;
        failures = 0;
        check_count = 0;
        foreach (known[i]) known[i] = 1'b0;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        wait_lock(n);
        // lock ends inside the last k period; its edge precedes any command
        `CHK(n >= (sram_link_pkg::DLL_LOCK_CYCLES - 1) * 8, 1'b1)
        $display("test lock done");
        // eight lane combinations (all, each single lane, low pair, high pair, none), varying per beat
        for (int t = 0; t < 8; t++) begin
            rand_burst(wd, m);
            issue(1'b1, 6'(t), wd, '0);
            rand_burst(wd, m);
            for (int j = 0; j < 4; j++) m[j] = mask_tab[(t + j) % 8];
            issue(1'b1, 6'(t), wd, m);
            issue(1'b0, 6'(t), wd, m);
        end
        $display("test lanes done");
        // random traffic
        for (int t = 0; t < 40; t++) begin
            rand_burst(wd, m);
            v = rnd();
            if (v[8]) m = '0;
            issue(v[0], v[6:1], wd, m);
        end
        $display("test random done");
        // relock after a clock change
        // hold the clock-change request until the lock wait restarts
        @(posedge i_clk);
        i_relock <= 1'b1;
        n = 0;
        while (o_locked !== 1'b0 && n < 200) begin
            @(posedge i_clk);
            n++;
        end
        i_relock <= 1'b0;
        if (n >= 200) give_up("relock");
        `CHK(o_locked, 1'b0)
        wait_lock(n);
        `CHK(n >= (sram_link_pkg::DLL_LOCK_CYCLES - 1) * 8, 1'b1)
        issue(1'b0, 6'h00, wd, m);
        $display("test relock done");
        // stopped link clock holds state
        @(posedge i_clk);
        i_pause <= 1'b1;
        repeat (16) @(posedge i_clk);
        k0 = link_if.k;
        moved = 1'b0;
        repeat (20) begin
            @(negedge i_clk);
            if (link_if.k !== k0) moved = 1'b1;
        end
        `CHK(moved, 1'b0)
        `CHK(o_busy, 1'b0)
        i_pause <= 1'b0;
        issue(1'b0, 6'h01, wd, m);
        $display("test pause done");
        final_report();
    end
endmodule
`default_nettype wire
